// File: hdl/dcc_osc_ctl.sv
// Oscillator control for one channel: frequency load and phase reset
`timescale 1ns/100ps
module dcc_osc_ctl
#(
  parameter int FW = 32 // Frequency word width
)
(
  input  wire logic          clk,       // System clock
  input  wire logic          srst,      // Synchronous reset
  input  wire logic          ce,        // Clock enable
  input  wire logic          restart,   // Reset phase, load freq
  input  wire logic          run,       // Mixer active
  input  wire logic          inv,       // Invert phase
  input  wire logic [FW-1:0] freq_in,   // Programmed frequency word
  output logic      [FW-1:0] phase      // Phase accumulator out
);

  logic [FW-1:0] freq_r;
  logic [FW-1:0] freq_nxt;
  logic [FW-1:0] acc_r;
  logic [FW-1:0] acc_nxt;

  // ==========================================================
  // Frequency is only taken at a restart so a half-written
  // word never disturbs the running oscillator
  // ==========================================================
  always_comb
  begin
    freq_nxt = freq_r;
    acc_nxt  = acc_r;
    if (restart)
    begin
      freq_nxt = freq_in;
      acc_nxt  = '0;
    end
    else if (run)
      acc_nxt = acc_r + freq_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      freq_r <= '0;
      acc_r  <= '0;
    end
    else if (ce)
    begin
      freq_r <= freq_nxt;
      acc_r  <= acc_nxt;
    end
  end

  // Inversion is a half-turn offset of the phase
  assign phase = inv ? (acc_r ^ {1'b1, {(FW-1){1'b0}}}) : acc_r;

endmodule

// File: hdl/dcc_regs.sv
// Register bank steering the optional decimating feature path
`timescale 1ns/100ps
module dcc_regs
#(
  parameter int FW = dcc_pkg::FREQ_W // Frequency word width
)
(
  input  wire logic                      clk,       // 20 MHz clock
  input  wire logic                      srst,      // Sync reset
  input  wire logic                      ce,        // Clock enable
  input  wire logic [dcc_pkg::ADDR_W-1:0] addr,     // Byte address
  input  wire logic [31:0]               wdata,     // Write data
  input  wire logic                      wr,        // Write strobe
  input  wire logic                      rd,        // Read strobe
  output logic      [31:0]               rdata,     // Read data
  input  wire logic [FW-1:0]             freq_a,    // Freq word A
  input  wire logic [FW-1:0]             freq_b,    // Freq word B
  output logic                           feature_path_select, // Path
  output logic                           scrambler_allow, // Path ok
  output dcc_pkg::dcc_chan_s             chan_a,    // Channel A ctl
  output dcc_pkg::dcc_chan_s             chan_b,    // Channel B ctl
  output logic [FW-1:0]                  phase_a,   // Osc phase A
  output logic [FW-1:0]                  phase_b    // Osc phase B
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [7:0]  fpc_r;
  logic [7:0]  fpc_nxt;
  logic [7:0]  dcfg_r;
  logic [7:0]  dcfg_nxt;
  logic [7:0]  mix_r;
  logic [7:0]  mix_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        path_r;
  logic        path_nxt;
  dcc_pkg::dcc_chan_s ca_r;
  dcc_pkg::dcc_chan_s ca_nxt;
  dcc_pkg::dcc_chan_s cb_r;
  dcc_pkg::dcc_chan_s cb_nxt;
  logic        rst_pulse_a;
  logic        rst_pulse_b;
  logic [FW-1:0] ph_a;
  logic [FW-1:0] ph_b;
  logic [FW-1:0] pha_r;
  logic [FW-1:0] phb_r;

  // ==========================================================
  // Bus writes and reads; all eight bits stored, reserved too
  // ==========================================================
  always_comb
  begin
    fpc_nxt   = fpc_r;
    dcfg_nxt  = dcfg_r;
    mix_nxt   = mix_r;
    rdata_nxt = 32'h0000_0000;
    if (wr)
    begin
      case (addr)
        dcc_pkg::FILTER_PATH_CONTROL_ADDR: fpc_nxt  = wdata[7:0];
        dcc_pkg::DECIMATION_CONFIG_ADDR:   dcfg_nxt = wdata[7:0];
        dcc_pkg::MIXER_CONTROL_ADDR:       mix_nxt  = wdata[7:0];
        default:                           fpc_nxt  = fpc_r;
      endcase
    end
    if (rd)
    begin
      case (addr)
        dcc_pkg::FILTER_PATH_CONTROL_ADDR: rdata_nxt = {24'h0, fpc_r};
        dcc_pkg::DECIMATION_CONFIG_ADDR:   rdata_nxt = {24'h0, dcfg_r};
        dcc_pkg::MIXER_CONTROL_ADDR:       rdata_nxt = {24'h0, mix_r};
        default:                           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fpc_r   <= dcc_pkg::FILTER_PATH_CONTROL_RST;
      dcfg_r  <= dcc_pkg::DECIMATION_CONFIG_RST;
      mix_r   <= dcc_pkg::MIXER_CONTROL_RST;
      rdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      fpc_r   <= fpc_nxt;
      dcfg_r  <= dcfg_nxt;
      mix_r   <= mix_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Decode fields into per-channel controls
  // ==========================================================
  always_comb
  begin
    logic       feat;
    logic       ddc_on;
    logic       route_on;
    logic [1:0] route;
    logic [2:0] dec;
    logic       is_real;
    feat     = fpc_r[dcc_pkg::PATH_SEL_BIT];
    ddc_on   = feat & fpc_r[dcc_pkg::DOWNCONVERTER_ENABLE_BIT];
    route_on = dcfg_r[dcc_pkg::ROUTE_EN_BIT];
    route    = fpc_r[dcc_pkg::ROUTE_LSB +: 2];
    dec      = dcfg_r[dcc_pkg::DECIM_LSB +: 3];
    is_real  = dcfg_r[dcc_pkg::REAL_OUT_BIT];
    // Unused decimation codes fall back to bypass
    if (dec > dcc_pkg::DECIM_MAX)
      dec = 3'h0;
    path_nxt = feat;
    ca_nxt.enable      = ddc_on;
    ca_nxt.src         = 2'h1;    // Channel A always fed by A
    ca_nxt.real_mode   = is_real;
    ca_nxt.decim       = dec;
    ca_nxt.phase_inv   = dcfg_r[dcc_pkg::PHASE_INV_BIT];
    ca_nxt.gain        = is_real ? 2'h0
                                 : mix_r[dcc_pkg::GAIN_A_LSB +: 2];
    if (ca_nxt.gain > dcc_pkg::GAIN_MAX)
      ca_nxt.gain = 2'h0;
    // Quarter-rate mixing has no meaning without complex mixing
    ca_nxt.quarter_mix = ~is_real & mix_r[dcc_pkg::QMIX_A_BIT];
    // Channel B shares every common field with channel A
    cb_nxt = ca_nxt;
    // Channel B only sees data when the mux is on and says both
    cb_nxt.src = (route_on && route == dcc_pkg::ROUTE_A_BOTH)
                 ? 2'h1 : 2'h0;
    cb_nxt.enable = ddc_on & cb_nxt.src[0];
    cb_nxt.gain = is_real ? 2'h0
                          : mix_r[dcc_pkg::GAIN_B_LSB +: 2];
    if (cb_nxt.gain > dcc_pkg::GAIN_MAX)
      cb_nxt.gain = 2'h0;
    cb_nxt.quarter_mix = ~is_real & mix_r[dcc_pkg::QMIX_B_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      path_r <= 1'b0;
      ca_r   <= '0;
      cb_r   <= '0;
      pha_r  <= '0;
      phb_r  <= '0;
    end
    else if (ce)
    begin
      path_r <= path_nxt;
      ca_r   <= ca_nxt;
      cb_r   <= cb_nxt;
      pha_r  <= ph_a;
      phb_r  <= ph_b;
    end
  end

  // ==========================================================
  // Oscillator restart on either edge of the stored reset bits
  // ==========================================================
  // Rewriting the same value is no toggle, so no restart follows
  dcc_toggle_det u_tog_a
  (
    .clk    (clk),
    .srst   (srst),
    .ce     (ce),
    .bit_in (mix_r[dcc_pkg::OSC_RST_A_BIT]),
    .pulse  (rst_pulse_a)
  );

  dcc_toggle_det u_tog_b
  (
    .clk    (clk),
    .srst   (srst),
    .ce     (ce),
    .bit_in (mix_r[dcc_pkg::OSC_RST_B_BIT]),
    .pulse  (rst_pulse_b)
  );

  // Real mode forces a zero frequency so the oscillator idles
  dcc_osc_ctl #(.FW(FW)) u_osc_a
  (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .restart (rst_pulse_a),
    .run     (ca_r.enable & ~ca_r.real_mode),
    .inv     (ca_r.phase_inv),
    .freq_in (ca_r.real_mode ? '0 : freq_a),
    .phase   (ph_a)
  );

  dcc_osc_ctl #(.FW(FW)) u_osc_b
  (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .restart (rst_pulse_b),
    .run     (cb_r.enable & ~cb_r.real_mode),
    .inv     (cb_r.phase_inv),
    .freq_in (cb_r.real_mode ? '0 : freq_b),
    .phase   (ph_b)
  );

  // ==========================================================
  // Outputs, all from flip-flops
  // ==========================================================
  assign rdata               = rdata_r;
  assign feature_path_select = path_r;
  assign scrambler_allow     = path_r;
  assign chan_a              = ca_r;
  assign chan_b              = cb_r;
  assign phase_a             = pha_r;
  assign phase_b             = phb_r;

endmodule

// File: hdl/dcc_toggle_det.sv
// Edge detector: one-cycle pulse on any change of a stored bit
`timescale 1ns/100ps
module dcc_toggle_det
(
  input  wire logic clk,    // System clock
  input  wire logic srst,   // Synchronous reset
  input  wire logic ce,     // Clock enable
  input  wire logic bit_in, // Stored register bit
  output logic      pulse   // One cycle per change
);

  logic prev_r;
  logic prev_nxt;
  logic pulse_r;
  logic pulse_nxt;

  // ==========================================================
  // Compare against last value; either edge counts
  // ==========================================================
  always_comb
  begin
    prev_nxt  = bit_in;
    pulse_nxt = bit_in ^ prev_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prev_r  <= 1'b0;
      pulse_r <= 1'b0;
    end
    else if (ce)
    begin
      prev_r  <= prev_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;

endmodule

// File: pkg/dcc_pkg.sv
// Package: register map, field positions, reset values and types
package dcc_pkg;

  // ==========================================================
  // Register indices and byte addresses
  // ==========================================================
  localparam logic [7:0] FILTER_PATH_CONTROL_IDX = 8'h24;
  localparam logic [7:0] DECIMATION_CONFIG_IDX   = 8'h25;
  localparam logic [7:0] MIXER_CONTROL_IDX       = 8'h26;
  localparam int         ADDR_W                  = 10;
  localparam logic [9:0] FILTER_PATH_CONTROL_ADDR =
    {FILTER_PATH_CONTROL_IDX, 2'b00};
  localparam logic [9:0] DECIMATION_CONFIG_ADDR   =
    {DECIMATION_CONFIG_IDX, 2'b00};
  localparam logic [9:0] MIXER_CONTROL_ADDR       =
    {MIXER_CONTROL_IDX, 2'b00};

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] FILTER_PATH_CONTROL_RST = 8'h00;
  localparam logic [7:0] DECIMATION_CONFIG_RST   = 8'h00;
  localparam logic [7:0] MIXER_CONTROL_RST       = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int ROUTE_LSB        = 3;
  localparam int PATH_SEL_BIT     = 2;
  localparam int DOWNCONVERTER_ENABLE_BIT       = 1;
  localparam int ROUTE_EN_BIT     = 7;
  localparam int DECIM_LSB        = 4;
  localparam int REAL_OUT_BIT     = 3;
  localparam int PHASE_INV_BIT    = 0;
  localparam int GAIN_A_LSB       = 6;
  localparam int OSC_RST_A_BIT    = 5;
  localparam int QMIX_A_BIT       = 4;
  localparam int GAIN_B_LSB       = 2;
  localparam int OSC_RST_B_BIT    = 1;
  localparam int QMIX_B_BIT       = 0;

  // ==========================================================
  // Codes
  // ==========================================================
  localparam logic [1:0] ROUTE_A_ONLY = 2'h0;
  localparam logic [1:0] ROUTE_A_BOTH = 2'h1;
  localparam logic [2:0] DECIM_MAX    = 3'h5;
  localparam logic [1:0] GAIN_MAX     = 2'h2;
  localparam int         FREQ_W       = 32;

  // Per-channel controls for one filter channel
  typedef struct packed {
    logic       enable;      // Filter channel runs
    logic [1:0] src;         // 0 none, 1 converter A
    logic       real_mode;   // Low-pass only, no mixing
    logic       quarter_mix; // Mix at quarter sample rate
    logic       phase_inv;   // Oscillator phase inverted
    logic [1:0] gain;        // 0, 3 or 6 dB after mixer
    logic [2:0] decim;       // Decimation ratio code
  } dcc_chan_s;

endpackage

// File: sim/dcc_regs_sva.sv
// Checker: port-level assertions for the register bank
`timescale 1ns/100ps
module dcc_regs_sva
(
  input wire logic               clk,                 // Clock
  input wire logic               srst,                // Sync reset
  input wire logic               ce,                  // Clock enable
  input wire logic [9:0]         addr,                // Byte address
  input wire logic [31:0]        wdata,               // Write data
  input wire logic               wr,                  // Write strobe
  input wire logic               rd,                  // Read strobe
  input wire logic [31:0]        rdata,               // Read data
  input wire logic               feature_path_select, // Path select
  input wire logic               scrambler_allow,     // Path ok
  input wire dcc_pkg::dcc_chan_s chan_a,              // Channel A
  input wire dcc_pkg::dcc_chan_s chan_b               // Channel B
);
  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Write to the path register, then one enabled cycle to decode
  sequence s_path_wr;
    ce && wr && addr == dcc_pkg::FILTER_PATH_CONTROL_ADDR ##1 ce;
  endsequence
  a_path_write: assert property (
    s_path_wr |=> feature_path_select == $past(wdata[2], 2))
    else $error("path select does not follow write");
  a_rdata_idle: assert property (
    ce && !rd |=> rdata == 32'h0)
    else $error("read data not zero outside read");
  a_rd_upper: assert property (
    ce && rd |=> rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_scr_mirror: assert property (
    feature_path_select == scrambler_allow)
    else $error("scrambler allow differs from path");
  a_path_gate: assert property (
    !feature_path_select |-> !chan_a.enable && !chan_b.enable)
    else $error("channel runs in bypass");
  a_b_needs_a: assert property (
    chan_b.enable |-> chan_a.enable && chan_b.src == 2'h1)
    else $error("channel B runs without A source");
  a_real_nomix: assert property (
    chan_a.real_mode |-> chan_a.gain == 2'h0 && !chan_a.quarter_mix)
    else $error("mixing controls active in real mode");
  a_gain_legal: assert property (
    chan_a.gain != 2'h3 && chan_b.gain != 2'h3)
    else $error("unused gain code decoded");
  a_decim_same: assert property (
    chan_a.enable && chan_b.enable |-> chan_a.decim == chan_b.decim
      && chan_a.decim <= dcc_pkg::DECIM_MAX)
    else $error("decimation differs or out of range");
endmodule
bind dcc_regs dcc_regs_sva i_dcc_regs_sva (.clk(clk), .srst(srst),
  .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .feature_path_select(feature_path_select),
  .scrambler_allow(scrambler_allow), .chan_a(chan_a), .chan_b(chan_b));

// File: sim/dcc_regs_tb_top.sv
// Testbench: register access, control decode and oscillator restart
`timescale 1ns/100ps
module dcc_regs_tb_top;
  localparam logic [9:0] R24 = dcc_pkg::FILTER_PATH_CONTROL_ADDR;
  localparam logic [9:0] R25 = dcc_pkg::DECIMATION_CONFIG_ADDR;
  localparam logic [9:0] R26 = dcc_pkg::MIXER_CONTROL_ADDR;
  logic               clk;             // Clock
  logic               srst;            // Reset
  logic               ce;              // Clock enable
  logic [9:0]         addr;            // Address
  logic [31:0]        wdata;           // Write data
  logic               wr;              // Write strobe
  logic               rd;              // Read strobe
  logic [31:0]        rdata;           // Read data
  logic [31:0]        freq_a;          // Frequency A
  logic [31:0]        freq_b;          // Frequency B
  logic               path_sel;        // Path select
  logic               scr_ok;          // Scrambler allow
  dcc_pkg::dcc_chan_s ca;              // Channel A controls
  dcc_pkg::dcc_chan_s cb;              // Channel B controls
  logic [31:0]        phase_a;         // Phase A
  logic [31:0]        phase_b;         // Phase B
  int                 n_fail;          // Mismatches
  int                 samples_checked; // Comparisons
  int                 cycles;          // Timeout count
  logic [7:0]         v;               // Mixer register image

  dcc_regs i_dcc_regs (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .freq_a(freq_a),
    .freq_b(freq_b), .feature_path_select(path_sel),
    .scrambler_allow(scr_ok), .chan_a(ca), .chan_b(cb),
    .phase_a(phase_a), .phase_b(phase_b));

  // ==========================================================
  // Bus tasks and comparison
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // Decoded controls land one cycle after the register
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_regs;
    rreg(R24, 32'h0);
    rreg(R26, 32'h0);
    wreg(R24, 32'hffff_ffe1);
    wreg(R25, 32'h0000_0006);
    rreg(R24, 32'h0000_00e1);
    rreg(R25, 32'h0000_0006);
    wreg(10'h09c, 32'h0000_00ff);
    rreg(10'h09c, 32'h0);
    // Frozen clock enable must drop the write
    @(posedge clk);
    ce <= 1'b0;
    wreg(R24, 32'h0);
    ce <= 1'b1;
    rreg(R24, 32'h0000_00e1);
    wreg(R25, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_route;
    for (int i = 0; i < 10; i++)
    begin
      wreg(R24, i < 8 ? 32'(i[1:0]) << 3 | 32'h6 : (i == 8 ? 32'ha : 32'hc));
      wreg(R25, 32'(i[2] | i > 7) << 7);
      settle();
      chk(32'(path_sel), 32'(i != 8));
      chk(32'(scr_ok), 32'(i != 8));
      chk(32'(cb.src), 32'(i == 5 || i > 7));
      chk(32'(ca.enable), 32'(i < 8));
      chk(32'(cb.enable), 32'(i < 8 && i[2] && i[1:0] == 2'h1));
    end
    $display("test route done");
  endtask
  task automatic t_decim;
    wreg(R24, 32'h0000_000e);
    for (int c = 0; c < 8; c++)
    begin
      wreg(R25, 32'h80 | 32'(c) << 4 | 32'(c & 1));
      settle();
      chk(32'(ca.decim), c < 6 ? 32'(c) : 32'h0);
      chk(32'(cb.decim), c < 6 ? 32'(c) : 32'h0);
      chk(32'(ca.phase_inv), 32'(c & 1));
    end
    $display("test decim done");
  endtask
  task automatic t_gain;
    wreg(R25, 32'h0000_0080);
    for (int g = 0; g < 4; g++)
    begin
      wreg(R26, 32'(g) << 6 | 32'(g) << 2 | 32'h11);
      settle();
      chk(32'(ca.gain), g < 3 ? 32'(g) : 32'h0);
      chk(32'(cb.gain), g < 3 ? 32'(g) : 32'h0);
      chk(32'({ca.quarter_mix, cb.quarter_mix}), 32'h3);
    end
    // Software parks the oscillators while real decimation runs
    @(posedge clk);
    freq_a <= 32'h0;
    freq_b <= 32'h0;
    wreg(R26, 32'h0000_0099);
    wreg(R25, 32'h0000_0088);
    settle();
    chk(32'({ca.real_mode, ca.gain, ca.quarter_mix}), 32'h8);
    @(posedge clk);
    freq_a <= 32'h3;
    freq_b <= 32'h5;
    $display("test gain done");
  endtask
  // Each restart clears the phase, then it climbs by the new word
  task automatic t_osc;
    wreg(R25, 32'h0000_0080);
    wreg(R26, 32'h0);
    v = 8'h00;
    for (int ch = 0; ch < 2; ch++)
    begin
      for (int t = 0; t < 3; t++)
      begin
        v = v ^ (ch ? 8'h02 : 8'h20);
        wreg(R26, 32'(v));
        @(negedge clk);
        for (int k = 0; k < 12 && (ch ? phase_b : phase_a) != 0; k++)
          @(negedge clk);
        if (t > 0)
        begin
          chk(ch ? phase_b : phase_a, 32'h0);
          @(negedge clk);
          chk(ch ? phase_b : phase_a, ch ? freq_b : freq_a);
          @(negedge clk);
          chk(ch ? phase_b : phase_a, ch ? 32'ha : 32'h6);
        end
        repeat (12) @(posedge clk);
      end
    end
    $display("test osc done");
  endtask
  // Inverted phase flips the top bit; a mid-run reset clears all
  task automatic t_reset;
    wreg(R25, 32'h0000_0081);
    settle();
    settle();
    chk(32'(phase_a[31]), 32'h1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rreg(R26, 32'h0);
    chk(32'({path_sel, ca.enable, cb.enable}), 32'h0);
    chk(phase_a | phase_b, 32'h0);
    $display("test reset done");
  endtask

  // ==========================================================
  // Clock, timeout and main sequence
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // A hang in any wait ends the run as a failure
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    {srst, ce, wr, rd} = 4'b1100;
    addr   = 10'h0;
    wdata  = 32'h0;
    freq_a = 32'h3;
    freq_b = 32'h5;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_route();
    t_decim();
    t_gain();
    t_osc();
    t_reset();
    give_verdict();
  end
endmodule
